/* hdl/sfpa_regs.svh */
// register offsets, reset values and field layout of the fabric arbiter
`ifndef SFPA_REGS_SVH
`define SFPA_REGS_SVH
`define SFPA_OFF_PRIO_A 8'h00
`define SFPA_OFF_PRIO_B 8'h04
`define SFPA_OFF_PRIO_C 8'h08
`define SFPA_OFF_STATUS 8'h0c
`define SFPA_OFF_CTRL 8'h10
`define SFPA_RST_PRIO_A 16'h0000
`define SFPA_RST_PRIO_B 16'h4317
`define SFPA_RST_PRIO_C 16'h0544
`define SFPA_MASK_PRIO_A 16'h7777
`define SFPA_MASK_PRIO_B 16'h7777
`define SFPA_MASK_PRIO_C 16'h0777
`define SFPA_RST_CTRL 32'h00000000
`define SFPA_FIELD_W 4
`define SFPA_LVL_W 3
`define SFPA_NUM_MST 12
`endif

/* hdl/sfpa_pkg.sv */
// types shared by the fabric arbiter files
package sfpa_pkg;
    // bus response codes
    typedef enum logic [1:0] {
        SFPA_OKAY = 2'b00,
        SFPA_SLVERR = 2'b10
    } sfpa_resp_e;

    // whole state of the register slave
    typedef struct packed {
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic awRdy;
        logic wRdy;
        logic arRdy;
        logic bValid;
        sfpa_resp_e bResp;
        logic rValid;
        logic [31:0] rData;
        sfpa_resp_e rResp;
        logic [15:0] prioA;
        logic [15:0] prioB;
        logic [15:0] prioC;
        logic [31:0] ctrl;
    } sfpa_axi_s;
endpackage

/* hdl/sfpa_ep_arb.sv */
// per-endpoint arbiter: priority select, round-robin on ties, burst hold
module sfpa_ep_arb import sfpa_pkg::*; #(
    parameter int NM = 12,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests aimed at this endpoint
    input wire logic [NM-1:0] req,
    input wire logic [NM*3-1:0] prio,
    input wire logic fifoMode,
    input wire logic burstEnd,
    // grant state
    output logic [NM-1:0] gnt,
    output logic busy
);
    localparam int CC = NM - 1; // channel controller, always first

    // whole endpoint state
    typedef struct packed {
        logic busy;
        logic [NM-1:0] gnt;
        logic [2:0] lvl;
        logic [7:0][3:0] rr;
        logic [NM-1:0][AW-1:0] age;
    } sfpa_arb_s;

    sfpa_arb_s s_q, s_d;
    logic [2:0] bestLvl; // most urgent level among requesters
    logic [3:0] win; // chosen master
    logic found;
    logic [AW-1:0] bestAge;
    int idx;

    // next-state logic
    always_comb begin
        s_d = s_q;
        bestLvl = 3'h7;
        win = 4'h0;
        found = 1'b0;
        bestAge = '0;
        idx = 0;
        // lowest value wins; 0 is most urgent
        for (int m = 0; m < CC; m++) begin
            if (req[m] && prio[m*3+:3] < bestLvl) begin
                bestLvl = prio[m*3+:3]; // see [R01] see [R02] see [R08]
            end
        end
        // waiting time stands in for arrival order in queue mode
        for (int m = 0; m < NM; m++) begin
            if (req[m] && !s_q.gnt[m]) begin
                if (s_q.age[m] != {AW{1'b1}}) begin
                    s_d.age[m] = s_q.age[m] + 1'b1;
                end
            end else begin
                s_d.age[m] = '0;
            end
        end
        if (req[CC]) begin
            win = 4'(CC); // see [R07]
            found = 1'b1;
        end else if (fifoMode) begin
            // oldest first, never by priority; blocking accepted
            for (int m = 0; m < NM; m++) begin
                if (req[m] && (!found || s_q.age[m] > bestAge)) begin
                    win = 4'(m); // see [R12]
                    bestAge = s_q.age[m];
                    found = 1'b1;
                end
            end
        end else begin
            // first tied master at or after the level pointer
            for (int k = 0; k < NM; k++) begin
                idx = int'(s_q.rr[bestLvl]) + k;
                if (idx >= NM) begin
                    idx = idx - NM;
                end
                if (!found && idx != CC && req[idx] && prio[idx*3+:3] == bestLvl) begin
                    win = 4'(idx); // see [R03]
                    found = 1'b1;
                end
            end
        end
        if (s_q.busy) begin
            // only a burst end reopens the path; write ends need no reply
            if (burstEnd) begin
                s_d.busy = 1'b0; // see [R11] see [R10]
                s_d.gnt = '0;
            end
        end else if (found) begin
            // levels are read live here, so a new setting acts now
            s_d.busy = 1'b1; // see [R14] see [R04]
            s_d.gnt = '0;
            s_d.gnt[win] = 1'b1;
            if (!req[CC] && !fifoMode) begin
                s_d.lvl = bestLvl;
                s_d.rr[bestLvl] = (win == 4'(NM - 1)) ? 4'h0 : win + 4'h1; // see [R13]
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign gnt = s_q.gnt;
    assign busy = s_q.busy;

    // checking helpers
    logic [3:0] gntIdx;
    logic olderLost;
    always_comb begin
        gntIdx = 4'h0;
        olderLost = 1'b0;
        for (int m = 0; m < NM; m++) begin
            if (s_q.gnt[m]) begin
                gntIdx = 4'(m);
            end
            for (int j = 0; j < NM; j++) begin
                if (s_d.gnt[m] && req[j] && s_q.age[j] > s_q.age[m]) begin
                    olderLost = 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_gnt_hold: assert property (busy && !burstEnd |=> $stable(gnt)) // see [R11]
        else $error("grant changed inside a burst");
    a_cc_wins: assert property (!busy && req[CC] |=> gnt[CC]) // see [R07]
        else $error("channel controller not granted first");
    a_best_lvl: assert property (!busy && |req && !req[CC] && !fifoMode
        |=> s_q.lvl == $past(bestLvl) && prio[gntIdx*3+:3] == $past(bestLvl)) // see [R02]
        else $error("grant not at the most urgent level");
    a_gnt_req: assert property ($rose(busy) |-> ($past(req) & gnt) == gnt && $onehot(gnt)) // see [R04]
        else $error("grant to a master that did not ask");
    a_rr_adv: assert property ($rose(busy) && $past(!fifoMode && !req[CC])
        |-> s_q.rr[s_q.lvl] == ((gntIdx == 4'(NM - 1)) ? 4'h0 : gntIdx + 4'h1)) // see [R13]
        else $error("level pointer did not pass the winner");
    a_release: assert property (busy && burstEnd |=> !busy && gnt == '0) // see [R10]
        else $error("path not released at burst end");
    a_fifo_old: assert property (!busy && fifoMode && |req && !req[CC] |-> !olderLost) // see [R12]
        else $error("queue mode skipped an older request");

    c_tie: cover property (!busy && $countones(req) > 1 && !fifoMode ##1 busy);
    c_fifo: cover property (!busy && fifoMode && $countones(req) > 1 ##1 busy);
    c_cc: cover property (!busy && req[CC] && $countones(req) > 1 ##1 gnt[CC]);
endmodule

/* hdl/sfpa_arbiter.sv */
// fabric priority arbiter top: register slave and one arbiter per endpoint
// Summary of operation
// [R01] each master holds level 0..7, 0 most urgent
// [R02] most urgent pending master is granted first
// [R03] tied masters rotate, one request per turn
// [R04] contention resolved separately for every endpoint
// [R05] levels set by three software priority registers
// [R06] reset levels: transfer 0, dma 7, others fixed
// [R07] channel controller always beats every other master
// [R08] memory endpoint serves most urgent pending first
// [R09] reading master waits for returned read data
// [R10] writes posted; next transaction issues without reply
// [R11] decisions only at burst boundaries, no preemption
// [R12] bridge endpoints keep strict arrival order
// [R13] level pointer moves past each granted master; the code moves it only on level grants, not on controller or queue-mode grants
// [R14] new level acts next decision, burst untouched
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`include "sfpa_regs.svh"
module sfpa_arbiter import sfpa_pkg::*; #(
    parameter int NEP = 4,
    parameter int EW = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus, write side
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus, read side
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // master requests; the last master is the channel controller
    input wire logic [`SFPA_NUM_MST-1:0] mReq,
    input wire logic [`SFPA_NUM_MST*EW-1:0] mEp,
    // endpoint side
    input wire logic [NEP-1:0] epBurstEnd,
    output logic [NEP*`SFPA_NUM_MST-1:0] epGrant,
    output logic [NEP-1:0] epBusy
);
    localparam int NM = `SFPA_NUM_MST;

    sfpa_axi_s s_q, s_d;
    logic [NM*3-1:0] prioFlat; // live levels for every master but the channel controller
    logic [NEP-1:0] busyVec;
    logic [15:0] src;
    logic [31:0] rdNext;
    sfpa_resp_e rdResp;
    logic doWrite;

    // merge a write into a stored register under its byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8+:8] = dat[b*8+:8];
            end
        end
        return r;
    endfunction

    // the channel controller has no field: its slot stays zero and is never
    // read, since its arbiter path wins ahead of any level compare
    // level fields: four per register, three in prioC, low three bits of each nibble
    always_comb begin
        prioFlat = '0;
        src = '0;
        for (int m = 0; m < NM - 1; m++) begin
            case (m / 4)
                0: src = s_q.prioA;
                1: src = s_q.prioB;
                default: src = s_q.prioC;
            endcase
            prioFlat[m*3+:3] = src[(m%4)*`SFPA_FIELD_W+:`SFPA_LVL_W]; // see [R05] see [R01]
        end
    end

    // status reads the live busy flags; the control word holds queue-mode bits
    // read data mux; unmapped offsets answer with an error
    always_comb begin
        rdNext = 32'h0;
        rdResp = SFPA_OKAY;
        case (s_axi_araddr)
            `SFPA_OFF_PRIO_A: rdNext = {16'h0, s_q.prioA};
            `SFPA_OFF_PRIO_B: rdNext = {16'h0, s_q.prioB};
            `SFPA_OFF_PRIO_C: rdNext = {16'h0, s_q.prioC};
            `SFPA_OFF_STATUS: rdNext = 32'(busyVec);
            `SFPA_OFF_CTRL: rdNext = s_q.ctrl;
            default: rdResp = SFPA_SLVERR;
        endcase
    end

    // timing seen by software: a joint address and data handshake is answered
    // two edges later, a read one edge later; the ready outputs stay low while
    // a transfer is held, which keeps one write and one read in flight at most
    // limitation: no outstanding queue, so back-to-back writes cost three edges
    // slave next state: address and data are taken in either order
    always_comb begin
        s_d = s_q;
        if (s_axi_awvalid && s_q.awRdy) begin
            s_d.awHave = 1'b1;
            s_d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wRdy) begin
            s_d.wHave = 1'b1;
            s_d.wData = s_axi_wdata;
            s_d.wStrb = s_axi_wstrb;
        end
        if (s_q.bValid && s_axi_bready) begin
            s_d.bValid = 1'b0;
        end
        doWrite = s_q.awHave && s_q.wHave && !s_q.bValid;
        if (doWrite) begin
            // reserved bits always stay zero
            s_d.awHave = 1'b0;
            s_d.wHave = 1'b0;
            s_d.bValid = 1'b1;
            s_d.bResp = SFPA_OKAY;
            case (s_q.awAddr)
                `SFPA_OFF_PRIO_A: s_d.prioA = 16'(merge({16'h0, s_q.prioA}, s_q.wData,
                    s_q.wStrb)) & `SFPA_MASK_PRIO_A; // see [R05]
                `SFPA_OFF_PRIO_B: s_d.prioB = 16'(merge({16'h0, s_q.prioB}, s_q.wData,
                    s_q.wStrb)) & `SFPA_MASK_PRIO_B;
                `SFPA_OFF_PRIO_C: s_d.prioC = 16'(merge({16'h0, s_q.prioC}, s_q.wData,
                    s_q.wStrb)) & `SFPA_MASK_PRIO_C;
                `SFPA_OFF_CTRL: s_d.ctrl = merge(s_q.ctrl, s_q.wData,
                    s_q.wStrb) & 32'((1 << NEP) - 1);
                `SFPA_OFF_STATUS: s_d.bResp = SFPA_OKAY; // read-only, write ignored
                default: s_d.bResp = SFPA_SLVERR;
            endcase
        end
        // the read side runs beside the write side and never waits on it
        if (s_q.rValid && s_axi_rready) begin
            s_d.rValid = 1'b0;
        end
        if (s_axi_arvalid && s_q.arRdy) begin
            s_d.rValid = 1'b1;
            s_d.rData = rdNext;
            s_d.rResp = rdResp;
        end
        // one write and one read in flight; ready drops while held
        s_d.awRdy = !s_d.awHave && !s_d.bValid;
        s_d.wRdy = !s_d.wHave && !s_d.bValid;
        s_d.arRdy = !s_d.rValid;
    end

    // reset loads the default level table so masters arbitrate at once
    // slave state register; defaults give the reset levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.prioA <= `SFPA_RST_PRIO_A; // see [R06]
            s_q.prioB <= `SFPA_RST_PRIO_B;
            s_q.prioC <= `SFPA_RST_PRIO_C;
            s_q.ctrl <= `SFPA_RST_CTRL;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awRdy;
    assign s_axi_wready = s_q.wRdy;
    assign s_axi_bvalid = s_q.bValid;
    assign s_axi_bresp = s_q.bResp;
    assign s_axi_arready = s_q.arRdy;
    assign s_axi_rvalid = s_q.rValid;
    assign s_axi_rdata = s_q.rData;
    assign s_axi_rresp = s_q.rResp;
    assign epBusy = busyVec;

    // every endpoint arbitrates alone, so a long burst at one endpoint never
    // stalls masters aimed at another; the level table is shared by all of them
    // one arbiter per endpoint; requests routed by target index
    for (genvar e = 0; e < NEP; e++) begin : g_ep
        logic [NM-1:0] reqE;
        always_comb begin
            for (int m = 0; m < NM; m++) begin
                reqE[m] = mReq[m] && (mEp[m*EW+:EW] == EW'(e)); // see [R04]
            end
        end
        sfpa_ep_arb #(.NM(NM), .AW(4)) u_arb (
            .clk(clk),
            .rst(rst),
            .req(reqE),
            .prio(prioFlat),
            .fifoMode(s_q.ctrl[e]), // see [R12]
            .burstEnd(epBurstEnd[e]),
            .gnt(epGrant[e*NM+:NM]),
            .busy(busyVec[e])
        );
    end

    // checks on the register slave
    a_prio_reset: assert property (@(posedge clk) disable iff (rst) $past(rst) |-> // see [R06]
        s_q.prioA == `SFPA_RST_PRIO_A && s_q.prioB == `SFPA_RST_PRIO_B &&
        s_q.prioC == `SFPA_RST_PRIO_C)
        else $error("levels not at defaults after reset");
    a_prio_write: assert property (@(posedge clk) disable iff (rst)
        doWrite && s_q.awAddr == `SFPA_OFF_PRIO_B && s_q.wStrb == 4'hf |=> // see [R05]
        s_axi_bvalid && s_q.prioB == ($past(s_q.wData[15:0]) & `SFPA_MASK_PRIO_B))
        else $error("level write not stored");
    c_wr: cover property (@(posedge clk) disable iff (rst) doWrite ##1 s_axi_bvalid);

    // the read path answers on the next edge and shuts the address channel
    a_rd_answer: assert property (@(posedge clk) disable iff (rst) // see [R05]
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered on the next edge");
    a_wr_busy: assert property (@(posedge clk) disable iff (rst) // see [R05]
        doWrite |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels open while a write is held");
    c_rd: cover property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
endmodule

/* tb/sfpa_ep_model.sv */
// endpoint model that closes each granted burst after a set delay
module sfpa_ep_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // grant state seen from the arbiter
    input wire logic [3:0] epBusy,
    // burst length in cycles; 0 answers at once
    input wire logic [3:0] burstLen,
    // burst finished pulses
    output logic [3:0] epBurstEnd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q [4]; // cycles spent in the current burst

    // the end pulse waits for the data to come back, so a slow slave stalls the
    // reading master; a zero length models a posted write
    always_ff @(posedge clk or posedge rst) begin
        for (int e = 0; e < 4; e++) begin
            if (rst) begin
                cnt_q[e] <= 4'h0;
                epBurstEnd[e] <= 1'b0;
            end else if (epBusy[e] && !epBurstEnd[e] && cnt_q[e] == burstLen) begin
                epBurstEnd[e] <= 1'b1;
            end else if (epBusy[e] && !epBurstEnd[e]) begin
                cnt_q[e] <= cnt_q[e] + 4'h1;
            end else begin
                // one pulse only: busy drops on the edge that sees it
                cnt_q[e] <= 4'h0;
                epBurstEnd[e] <= 1'b0;
            end
        end
    end
endmodule

/* tb/testbench.sv */
// self-checking bench for the fabric priority arbiter
`include "sfpa_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    // register bus, master side
    logic [7:0] awAddr = 8'h00;
    logic awValid = 1'b0;
    logic awReady;
    logic [31:0] wData = 32'h0;
    logic [3:0] wStrb = 4'hf;
    logic wValid = 1'b0;
    logic wReady;
    logic [1:0] bResp;
    logic bValid;
    logic bReady = 1'b0;
    logic [7:0] arAddr = 8'h00;
    logic arValid = 1'b0;
    logic arReady;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic rValid;
    logic rReady = 1'b0;
    // masters and endpoints
    logic [11:0] mReq = 12'h000;
    logic [23:0] mEp = 24'h0;
    logic [3:0] epBurstEnd;
    logic [47:0] epGrant;
    logic [3:0] epBusy;
    logic [3:0] burstLen = 4'h0;
    int num_errors = 0;
    int compares = 0;

    sfpa_arbiter #(.NEP(4), .EW(2)) DUT (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .mReq(mReq), .mEp(mEp),
        .epBurstEnd(epBurstEnd), .epGrant(epGrant), .epBusy(epBusy)
    );
    sfpa_ep_model MODEL (
        .clk(clk), .rst(rst), .epBusy(epBusy), .burstLen(burstLen),
        .epBurstEnd(epBurstEnd)
    );

    // free-running system clock, 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    // one comparison, counted
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bus write; address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awAddr <= a;
        awValid <= 1'b1;
        wData <= d;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!bValid && n < 200) begin
            @(posedge clk);
            n++;
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end
        bReady <= 1'b0;
        chk("bvalid", 32'h1, 32'(bValid));
        chk("bresp", 32'(er), 32'(bResp));
    endtask

    // bus read; data and code checked at the first edge that sees rvalid, one edge after the handshake
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        while (!rValid && n < 200) begin
            @(posedge clk);
            n++;
            if (arReady) arValid <= 1'b0;
        end
        rReady <= 1'b0;
        chk("rvalid", 32'h1, 32'(rValid));
        chk("rdata", ed, rData);
        chk("rresp", 32'(er), 32'(rResp));
    endtask

    // raise a master request toward an endpoint; call just after an edge
    task automatic rq(input int m, input logic [1:0] e);
        mReq[m] <= 1'b1;
        mEp[m*2+:2] <= e;
    endtask

    // expect master m to win endpoint e, hold it whole burst, then retire it
    task automatic win(input int e, input int m);
        logic [11:0] g;
        int n;
        g = 12'h001 << m;
        n = 0;
        @(negedge clk);
        while (!epBusy[e] && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("grant", 32'(g), 32'(epGrant[e*12+:12]));
        while (!epBurstEnd[e] && n < 200) begin
            @(negedge clk);
            n++;
            chk("held grant", 32'(g), 32'(epGrant[e*12+:12]));
        end
        chk("burst end", 32'h1, 32'(epBurstEnd[e]));
        // dropped before the next decision edge so it is not served twice
        @(posedge clk);
        mReq[m] <= 1'b0;
    endtask

    // reset values, read-only, unmapped and masked fields
    task automatic s_regs();
        rd(`SFPA_OFF_PRIO_A, 32'h00000000, 2'b00);
        rd(`SFPA_OFF_PRIO_B, 32'h00004317, 2'b00);
        rd(`SFPA_OFF_PRIO_C, 32'h00000544, 2'b00);
        rd(`SFPA_OFF_CTRL, 32'h00000000, 2'b00);
        wr(`SFPA_OFF_STATUS, 32'hffffffff, 2'b00);
        rd(`SFPA_OFF_STATUS, 32'h00000000, 2'b00);
        wr(8'h20, 32'h00000001, 2'b10);
        rd(8'h20, 32'h00000000, 2'b10);
        wr(`SFPA_OFF_PRIO_B, 32'hffffffff, 2'b00);
        rd(`SFPA_OFF_PRIO_B, 32'h00007777, 2'b00);
        wr(`SFPA_OFF_PRIO_B, 32'h00004317, 2'b00);
        wr(`SFPA_OFF_PRIO_C, 32'hffffffff, 2'b00);
        rd(`SFPA_OFF_PRIO_C, 32'h00000777, 2'b00);
        wr(`SFPA_OFF_PRIO_C, 32'h00000544, 2'b00);
    endtask

    // urgency, controller override, tie rotation, independent endpoints
    task automatic s_arb();
        @(posedge clk);
        rq(10, 2'd0);
        rq(6, 2'd0);
        rq(0, 2'd1);
        rq(11, 2'd1);
        win(0, 6);
        win(0, 10);
        win(1, 11);
        win(1, 0);
        rq(7, 2'd2);
        win(2, 7);
        // let the release of the last request take effect before asking again
        @(posedge clk);
        rq(7, 2'd2);
        rq(9, 2'd2);
        win(2, 9);
        win(2, 7);
        burstLen <= 4'h8;
        rq(6, 2'd0);
        rq(10, 2'd1);
        repeat (3) @(negedge clk);
        chk("busy pair", 32'h3, 32'(epBusy[1:0]));
        win(0, 6);
        win(1, 10);
    endtask

    // reprogrammed level, then arrival order on a queued endpoint
    task automatic s_prog();
        wr(`SFPA_OFF_PRIO_C, 32'h00000044, 2'b00);
        @(posedge clk);
        rq(6, 2'd0);
        rq(10, 2'd0);
        win(0, 10);
        win(0, 6);
        wr(`SFPA_OFF_PRIO_C, 32'h00000544, 2'b00);
        wr(`SFPA_OFF_CTRL, 32'h00000001, 2'b00);
        @(posedge clk);
        rq(5, 2'd0);
        repeat (2) @(posedge clk);
        rq(10, 2'd0);
        repeat (3) @(posedge clk);
        rq(0, 2'd0);
        win(0, 5);
        win(0, 10);
        win(0, 0);
        wr(`SFPA_OFF_CTRL, 32'h00000000, 2'b00);
    endtask

    // verdict and end of run
    task automatic wrap_up();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence: reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        s_regs();
        s_arb();
        s_prog();
        wrap_up();
    end

    // watchdog: the scenarios need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
